// ### rtl/fsp_core_ctl.sv
// Five-stage in-order pipeline control with memory-stage stalls
`timescale 1ns/1ps

module fsp_core_ctl #(
  parameter fsp_pkg::fsp_mul_t MUL_KIND = fsp_pkg::MUL_NONE,
  parameter logic [31:0]       RESET_PC = fsp_pkg::FSP_RESET_PC,
  parameter logic [31:0]       EXC_VEC  = fsp_pkg::FSP_EXC_VEC,
  parameter logic [31:0]       BRK_VEC  = fsp_pkg::FSP_BRK_VEC
)
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire fsp_pkg::fsp_ibus_in_t  ib_in,
  output wire fsp_pkg::fsp_ibus_out_t ib_out,
  output wire logic [31:0]            d_instr,
  input  wire fsp_pkg::fsp_dec_t      dec,
  input  wire logic                   ex_taken,
  input  wire logic [31:0]            ex_target,
  input  wire fsp_pkg::fsp_dbus_in_t  db_in,
  output wire fsp_pkg::fsp_dbus_out_t db_out,
  input  wire logic                   ci_stall,
  output wire logic                   ci_start,
  input  wire logic                   irq,
  output wire logic                   dispatch,
  output wire fsp_pkg::fsp_ret_t      retire,
  output wire logic                   flush,
  output wire fsp_pkg::fsp_exc_t      exc
);
  import fsp_pkg::*;

  fsp_state_t  s;         // Registered state
  fsp_state_t  next_s;    // Next state
  fsp_stage_t  e_res;     // Execute record with branch outcome
  fsp_stage_t  d_res;     // Decode record with decoder answer
  fsp_stage_t  word;      // Freshly fetched instruction
  logic        cnt_busy;  // Multicycle counter still running
  logic        cnt_load;  // Start a multicycle count
  logic [5:0]  cnt_val;   // Extra cycles to count
  logic        m_busy;    // Memory stage not finished
  logic        adv;       // Pipeline moves this cycle
  logic        redir;     // Memory stage flushes and redirects
  logic [31:0] redir_pc;  // Where fetch resumes after a flush
  fsp_cause_t  cause;     // Exception raised by the flush
  logic        pred;      // Taken prediction leaves decode now
  logic        fetch_ok;  // Returned word belongs to current path
  logic [31:0] ofs_ext;   // Sign-extended branch offset

  // Outputs come straight from the state register
  assign ib_out   = s.ib;
  assign db_out   = s.db;
  assign d_instr  = s.d.instr;
  assign ci_start = s.ci_start;
  assign dispatch = s.dispatch;
  assign flush    = s.flush;
  assign exc      = s.exc;
  assign retire   = '{valid: s.w.valid, pc: s.w.pc};

  // Branch offset widened to address width
  assign ofs_ext = {{16{dec.offset[FSP_OFS_SIGN]}}, dec.offset};

  // Extra memory-stage cycles for shifts, multiplies, cache ops
  fsp_mcyc #(
    .W (6)
  ) u_mcyc (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (cnt_load),
    .load_val (cnt_val),
    .busy     (cnt_busy)
  );

  // Memory-stage completion; the only source of a stall
  // Memory stage alone
  assign m_busy = cnt_busy
               || (s.ms == MS_BUS)
               || (s.ms == MS_RDWAIT && !db_in.readdatavalid)
               || (s.ms == MS_CI)
               || (s.ms == MS_CIWAIT && ci_stall);

  // Bubbles never stall; a busy valid instruction freezes D, E and M while fetch runs on
  // Hold earlier stages
  assign adv = !(s.m.valid && m_busy);

  // Next-state logic for stages, fetch and memory phase
  always_comb
  begin
    next_s = s;
    next_s.dispatch = 1'b0;
    next_s.flush = 1'b0;
    next_s.ci_start = 1'b0;
    next_s.exc = '0;
    cnt_load = 1'b0;
    cnt_val = '0;
    redir = 1'b0;
    redir_pc = s.m.pc + FSP_INSN_BYTES;
    cause = CAUSE_NONE;
    fetch_ok = 1'b0;
    word = '0;

    // Execute: resolve branch and capture jump target
    e_res = s.e;
    if (s.e.cls == CLS_BRANCH)
    begin
      e_res.mispred = (ex_taken != s.e.pred);
      e_res.target = ex_taken ? s.e.target
                              : s.e.pc + FSP_INSN_BYTES;
    end
    else if (s.e.cls == CLS_JUMP)
    begin
      e_res.target = ex_target;
    end

    // Decode: class from decoder, static prediction by offset sign
    // Backward taken only
    d_res = s.d;
    d_res.cls = dec.cls;
    d_res.shamt = dec.shamt;
    d_res.target = s.d.pc + FSP_INSN_BYTES + ofs_ext;
    d_res.pred = (dec.cls == CLS_BRANCH) && dec.offset[FSP_OFS_SIGN];

    // Memory stage leaving: decide on flush and exception
    if (s.m.valid && adv)
    begin
      case (s.m.cls)
        CLS_JUMP:
        begin
          redir = 1'b1;
          redir_pc = s.m.target;
        end
        CLS_FLUSH_SEQ:
        begin
          redir = 1'b1;
        end
        CLS_TRAP:
        begin
          redir = 1'b1;
          redir_pc = EXC_VEC;
          cause = CAUSE_TRAP;
        end
        CLS_ILLEGAL:
        begin
          redir = 1'b1;
          redir_pc = EXC_VEC;
          cause = CAUSE_ILLEGAL;
        end
        CLS_UNIMPL:
        begin
          redir = 1'b1;
          redir_pc = EXC_VEC;
          cause = CAUSE_UNIMPL;
        end
        // Without multiplier a multiply is emulated in software
        CLS_MUL:
        begin
          if (MUL_KIND == MUL_NONE)
          begin
            redir = 1'b1;
            redir_pc = EXC_VEC;
            cause = CAUSE_UNIMPL;
          end
        end
        // Break goes to the debug entry
        CLS_BREAK:
        begin
          redir = 1'b1;
          redir_pc = BRK_VEC;
        end
        CLS_BRANCH:
        begin
          if (s.m.mispred)
          begin
            redir = 1'b1;
            redir_pc = s.m.target;
          end
        end
        default:
        begin
          redir = 1'b0;
        end
      endcase
      // Interrupt taken after the leaving instruction
      if (!redir && irq)
      begin
        redir = 1'b1;
        redir_pc = EXC_VEC;
        cause = CAUSE_IRQ;
      end
    end
    next_s.flush = redir;
    next_s.exc.valid = (cause != CAUSE_NONE);
    next_s.exc.cause = cause;

    // Prediction acts only if the pipeline moves and no flush wins
    pred = s.d.valid && d_res.pred && adv && !redir;

    if (adv)
    begin
      // In order, one dispatch, one retire
      next_s.w = s.m;
      // Flush cancels execute, decode and fetch
      next_s.m = redir ? '0 : e_res;
      next_s.e = redir ? '0 : d_res;
      next_s.dispatch = !redir && s.d.valid;
      // Predicted taken drops the fall-through word
      next_s.d = (redir || pred) ? '0 : s.f;
      next_s.f = '0;
      if (redir || pred)
      begin
        next_s.fb = '0;
      end
      // Memory phase for the instruction entering M
      next_s.ms = MS_DONE;
      next_s.db = '0;
      if (!redir && s.e.valid)
      begin
        case (s.e.cls)
          CLS_LOAD:
          begin
            next_s.ms = MS_BUS;
            next_s.db.read = 1'b1;
          end
          CLS_STORE:
          begin
            next_s.ms = MS_BUS;
            next_s.db.write = 1'b1;
          end
          CLS_CI_MULTI:
          begin
            next_s.ms = MS_CI;
            next_s.ci_start = 1'b1;
          end
          // Without multiplier one bit per cycle, 1 to 32 cycles; with a multiplier a fixed 3 or 4 cycles
          CLS_SHIFT:
          begin
            cnt_load = 1'b1;
            if (MUL_KIND == MUL_NONE)
            begin
              cnt_val = {1'b0, s.e.shamt};
            end
            else if (MUL_KIND == MUL_EMB)
            begin
              cnt_val = FSP_EMB_EXTRA;
            end
            else
            begin
              cnt_val = FSP_LE_EXTRA;
            end
          end
          CLS_MUL:
          begin
            cnt_load = (MUL_KIND != MUL_NONE);
            cnt_val = (MUL_KIND == MUL_EMB) ? FSP_EMB_EXTRA
                                            : FSP_LE_EXTRA;
          end
          // Cache line ops: four cycles, no flush
          CLS_CACHE_OP:
          begin
            cnt_load = 1'b1;
            cnt_val = FSP_CACHE_EXTRA;
          end
          default:
          begin
            next_s.ms = MS_DONE;
          end
        endcase
      end
    end
    else
    begin
      // Stalled: writeback gets a bubble, D, E and M hold, the memory phase steps on
      next_s.w = '0;
      case (s.ms)
        MS_BUS:
        begin
          if (!db_in.waitrequest)
          begin
            next_s.db = '0;
            next_s.ms = s.db.read ? MS_RDWAIT : MS_DONE;
          end
        end
        // First custom cycle passes; then follow its stall
        MS_CI:
        begin
          next_s.ms = MS_CIWAIT;
        end
        default:
        begin
          next_s.ms = s.ms;
        end
      endcase
    end

    // Redirect fetch while cancelling wrong-path words
    if (redir || pred)
    begin
      next_s.fpc = redir ? redir_pc : d_res.target;
      next_s.drop = (s.fe != FE_IDLE);
    end

    // Fetch sequencer: one read outstanding at a time
    case (s.fe)
      FE_IDLE:
      begin
        if (!next_s.fb.valid)
        begin
          next_s.ib.read = 1'b1;
          next_s.ib.address = next_s.fpc;
          next_s.fe = FE_REQ;
        end
      end
      // Address stays put until the slave takes it
      FE_REQ:
      begin
        if (!ib_in.waitrequest)
        begin
          next_s.ib.read = 1'b0;
          next_s.fe = FE_WAIT;
          if (!s.drop && !(redir || pred))
          begin
            next_s.fpc = s.fpc + FSP_INSN_BYTES;
          end
        end
      end
      // Nothing enters fetch until data returns
      FE_WAIT:
      begin
        if (ib_in.readdatavalid)
        begin
          next_s.fe = FE_IDLE;
          next_s.drop = 1'b0;
          fetch_ok = !s.drop && !(redir || pred);
        end
      end
      default:
      begin
        next_s.fe = FE_IDLE;
      end
    endcase

    // Parked word moves up first so order is kept
    if (!next_s.f.valid && next_s.fb.valid)
    begin
      next_s.f = next_s.fb;
      next_s.fb = '0;
    end
    // A word arriving into a held fetch stage is parked
    if (fetch_ok)
    begin
      word.valid = 1'b1;
      word.pc = s.ib.address;
      word.instr = ib_in.readdata;
      if (!next_s.f.valid)
      begin
        next_s.f = word;
      end
      else
      begin
        next_s.fb = word;
      end
    end
  end

  // State register, synchronous reset; fetch starts at the reset address
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.fpc <= RESET_PC;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : fsp_core_ctl

// ### rtl/fsp_mcyc.sv
// Down-counter that holds the memory stage for extra cycles
`timescale 1ns/1ps
module fsp_mcyc #(
  parameter int W = fsp_pkg::FSP_CNT_W
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output wire logic         busy
);
  import fsp_pkg::*;

  // Counter state
  typedef struct packed {
    logic [W-1:0] cnt;
  } fsp_mcyc_st_t;

  fsp_mcyc_st_t s;       // Current count
  fsp_mcyc_st_t next_s;  // Next count

  // Busy while cycles remain; zero means the operation ends now
  assign busy = (s.cnt != '0);

  // Load wins over counting so a new operation never inherits a tail
  always_comb
  begin
    next_s = s;
    if (load)
    begin
      next_s.cnt = load_val;
    end
    else if (busy)
    begin
      next_s.cnt = s.cnt - W'(1);
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : fsp_mcyc

// ### rtl/fsp_pkg.sv
// Shared types and constants of the five-stage pipeline control
package fsp_pkg;

  // Bytes per instruction word, used for sequential fetch and return
  localparam logic [31:0] FSP_INSN_BYTES = 32'h0000_0004;
  // Default start address after reset
  localparam logic [31:0] FSP_RESET_PC   = 32'h0000_0000;
  // Default exception and break vectors
  localparam logic [31:0] FSP_EXC_VEC    = 32'h0000_0020;
  localparam logic [31:0] FSP_BRK_VEC    = 32'h0000_0040;
  // Width of the multicycle down-counter
  localparam int          FSP_CNT_W      = 6;
  // Memory-stage occupancy minus one, per multicycle operation
  localparam logic [5:0]  FSP_EMB_EXTRA  = 6'h02;
  localparam logic [5:0]  FSP_LE_EXTRA   = 6'h03;
  localparam logic [5:0]  FSP_CACHE_EXTRA = 6'h03;
  // Sign bit of the branch offset field
  localparam int          FSP_OFS_SIGN   = 15;

  // Instruction classes as reported by the decoder
  typedef enum logic [3:0] {
    CLS_ALU, CLS_CI_COMB, CLS_CI_MULTI, CLS_BRANCH,
    CLS_JUMP, CLS_FLUSH_SEQ, CLS_CACHE_OP, CLS_RDCTL,
    CLS_LOAD, CLS_STORE, CLS_SHIFT, CLS_MUL,
    CLS_TRAP, CLS_BREAK, CLS_ILLEGAL, CLS_UNIMPL
  } fsp_cls_t;

  // Hardware multiplier option
  typedef enum logic [1:0] {MUL_NONE, MUL_EMB, MUL_LE} fsp_mul_t;

  // Exception causes
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_IRQ, CAUSE_TRAP, CAUSE_ILLEGAL, CAUSE_UNIMPL
  } fsp_cause_t;

  // Fetch sequencer states
  typedef enum logic [1:0] {FE_IDLE, FE_REQ, FE_WAIT} fsp_fe_t;

  // Memory-stage phases
  typedef enum logic [2:0] {
    MS_DONE, MS_BUS, MS_RDWAIT, MS_CI, MS_CIWAIT
  } fsp_ms_t;

  // Decoder answer for the instruction in decode
  typedef struct packed {
    fsp_cls_t    cls;
    logic [15:0] offset;
    logic [4:0]  shamt;
  } fsp_dec_t;

  // One pipeline stage record
  typedef struct packed {
    logic        valid;
    fsp_cls_t    cls;
    logic        pred;
    logic        mispred;
    logic [4:0]  shamt;
    logic [31:0] pc;
    logic [31:0] instr;
    logic [31:0] target;
  } fsp_stage_t;

  // Instruction bus, master side and slave answers
  typedef struct packed {
    logic        read;
    logic [31:0] address;
  } fsp_ibus_out_t;

  typedef struct packed {
    logic        waitrequest;
    logic        readdatavalid;
    logic [31:0] readdata;
  } fsp_ibus_in_t;

  // Data bus strobes and slave answers
  typedef struct packed {
    logic read;
    logic write;
  } fsp_dbus_out_t;

  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
  } fsp_dbus_in_t;

  // Retirement and exception reports
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
  } fsp_ret_t;

  typedef struct packed {
    logic       valid;
    fsp_cause_t cause;
  } fsp_exc_t;

  // Whole state of the pipeline control
  typedef struct packed {
    fsp_stage_t    f;
    fsp_stage_t    d;
    fsp_stage_t    e;
    fsp_stage_t    m;
    fsp_stage_t    w;
    fsp_stage_t    fb;
    fsp_fe_t       fe;
    logic          drop;
    logic [31:0]   fpc;
    fsp_ms_t       ms;
    fsp_ibus_out_t ib;
    fsp_dbus_out_t db;
    logic          ci_start;
    logic          dispatch;
    logic          flush;
    fsp_exc_t      exc;
  } fsp_state_t;

endpackage : fsp_pkg

// ### test/fsp_core_ctl_bench.sv
// Self-checking bench for the pipeline control
`timescale 1ns/1ps
module fsp_core_ctl_bench;
  import fsp_pkg::*;
  logic          clk = 1'b0, rst_n = 1'b0, irq = 1'b0, ex_taken = 1'b0;
  logic [31:0]   ex_target = 32'h0000_0000, d_instr;
  logic [7:0]    iwait = 8'h00, dwait = 8'h00, ciwait = 8'h00;
  fsp_ibus_in_t  ib_in;
  fsp_ibus_out_t ib_out;
  fsp_dec_t      dec;
  fsp_dbus_in_t  db_in;
  fsp_dbus_out_t db_out;
  fsp_ret_t      retire;
  fsp_exc_t      exc;
  fsp_cause_t    ex_c;
  logic          ci_stall, ci_start, dispatch, flush;
  int            err_count, comparisons, cyc, fl_n, ex_n, ds_n;
  int            rt_t[$];  // Cycle of each retirement
  logic [31:0]   rt_pc[$]; // Pc of each retirement

  always #2 clk = ~clk;

  fsp_core_ctl fsp_core_ctl_i (.clk(clk), .rst_n(rst_n), .ib_in(ib_in),
    .ib_out(ib_out), .d_instr(d_instr), .dec(dec), .ex_taken(ex_taken),
    .ex_target(ex_target), .db_in(db_in), .db_out(db_out),
    .ci_stall(ci_stall), .ci_start(ci_start), .irq(irq),
    .dispatch(dispatch), .retire(retire), .flush(flush), .exc(exc));
  fsp_far_model fsp_far_model_i (.clk(clk), .rst_n(rst_n), .ib_out(ib_out),
    .ib_in(ib_in), .d_instr(d_instr), .dec(dec), .db_out(db_out),
    .db_in(db_in), .ci_start(ci_start), .ci_stall(ci_stall),
    .iwait(iwait), .dwait(dwait), .ciwait(ciwait));

  // Log retirements, flushes and exceptions; cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (retire.valid === 1'b1)
    begin
      rt_t.push_back(cyc);
      rt_pc.push_back(retire.pc);
    end
    if (dispatch === 1'b1)
      ds_n++;
    if (flush === 1'b1)
      fl_n++;
    if (exc.valid === 1'b1)
    begin
      ex_n++;
      ex_c = exc.cause;
    end
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [31:0] op(input fsp_cls_t c,
                                     input logic [15:0] o,
                                     input logic [4:0] s);
    return {7'h00, s, o, c};
  endfunction : op

  // Reset for three cycles; the program is loaded while fetch is idle
  task automatic restart(input logic [31:0] p0, p1,
                         input logic [7:0] iw, dw, cw);
    rst_n  <= 1'b0;
    iwait  <= iw;
    dwait  <= dw;
    ciwait <= cw;
    @(posedge clk);
    for (int k = 0; k < 64; k++)
      fsp_far_model_i.mem[k] = 32'h0000_0000;
    fsp_far_model_i.mem[0] = p0;
    fsp_far_model_i.mem[1] = p1;
    repeat (2) @(posedge clk);
    // Outputs are zero since two edges, so no stale event can follow
    rt_t.delete();
    rt_pc.delete();
    fl_n = 0;
    ex_n = 0;
    ds_n = 0;
    chk(retire.valid === 1'b0 && flush === 1'b0, "busy in reset");
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(ib_out.read === 1'b1 && ib_out.address === FSP_RESET_PC,
        "first fetch");
  endtask : restart

  task automatic wait_ret(input int n);
    repeat (300)
      if (rt_t.size() < n)
        @(posedge clk);
    // A run-out limit is a mismatch of its own
    if (rt_t.size() < n)
      chk(1'b0, "retire timeout");
  endtask : wait_ret

  // Slow instruction slave sets the pace: three refusals, then six
  // cycles per word since only one read is ever outstanding
  task automatic t_stream();
    restart(32'h0000_0000, 32'h0000_0000, 8'h03, 8'h00, 8'h00);
    wait_ret(6);
    for (int k = 1; k < 6; k++)
      chk(rt_pc[k] === 32'(4 * k) && rt_t[k] - rt_t[k-1] == 6,
          "stream order or pace");
    chk(ds_n == 6, "one dispatch per retired word");
  endtask : t_stream

  // A slow load leaves D and E empty behind it (no catching up), so the
  // next retire gap is the M cost plus two refill cycles
  task automatic t_cost(input fsp_cls_t c, input logic [4:0] s,
                        input logic [7:0] cw, input int exp);
    restart(op(CLS_LOAD, 16'h0000, 5'h00), op(c, 16'h0008, s),
            8'h00, 8'h06, cw);
    wait_ret(2);
    chk(rt_pc[1] === 32'h0000_0004, "retire order");
    chk(rt_t[1] - rt_t[0] == exp + 2, "memory stage cost");
  endtask : t_cost

  // Control transfer at pc 4: next retired pc, flushes, cause
  task automatic t_ctl(input fsp_cls_t c, input logic [15:0] o,
                       input logic tk, input logic [31:0] pc,
                       input int fl, input fsp_cause_t cs);
    ex_taken  <= tk;
    ex_target <= 32'h0000_0030;
    restart(32'h0000_0000, op(c, o, 5'h00), 8'h00, 8'h00, 8'h00);
    wait_ret(3);
    chk(rt_pc[1] === 32'h0000_0004 && rt_pc[2] === pc, "flow");
    chk(fl_n == fl, "flush count");
    chk(ex_n == (cs != CAUSE_NONE) && (ex_n == 0 || ex_c === cs),
        "exception cause");
  endtask : t_ctl

  task automatic t_irq();
    restart(32'h0000_0000, 32'h0000_0000, 8'h00, 8'h00, 8'h00);
    wait_ret(2);
    irq <= 1'b1;
    repeat (60)
      if (ex_n == 0)
        @(posedge clk);
    irq <= 1'b0;
    repeat (2) @(posedge clk);
    chk(ex_n == 1 && ex_c === CAUSE_IRQ && fl_n == 1, "interrupt");
  endtask : t_irq

  initial
  begin
    t_stream();
    t_cost(CLS_ALU, 5'h00, 8'h00, 1);
    t_cost(CLS_RDCTL, 5'h00, 8'h00, 1);
    t_cost(CLS_CI_COMB, 5'h00, 8'h00, 1);
    t_cost(CLS_BRANCH, 5'h00, 8'h00, 1);
    t_cost(CLS_SHIFT, 5'h00, 8'h00, 1);
    t_cost(CLS_SHIFT, 5'h1f, 8'h00, 32);
    t_cost(CLS_CACHE_OP, 5'h00, 8'h00, 4);
    t_cost(CLS_LOAD, 5'h00, 8'h00, 8);
    t_cost(CLS_STORE, 5'h00, 8'h00, 8);
    t_cost(CLS_CI_MULTI, 5'h00, 8'h00, 2);
    t_cost(CLS_CI_MULTI, 5'h00, 8'h03, 5);
    t_ctl(CLS_JUMP, 16'h0000, 1'b0, 32'h0000_0030, 1, CAUSE_NONE);
    t_ctl(CLS_FLUSH_SEQ, 16'h0000, 1'b0, 32'h0000_0008, 1,
          CAUSE_NONE);
    t_ctl(CLS_TRAP, 16'h0000, 1'b0, FSP_EXC_VEC, 1, CAUSE_TRAP);
    t_ctl(CLS_BREAK, 16'h0000, 1'b0, FSP_BRK_VEC, 1, CAUSE_NONE);
    t_ctl(CLS_ILLEGAL, 16'h0000, 1'b0, FSP_EXC_VEC, 1,
          CAUSE_ILLEGAL);
    t_ctl(CLS_UNIMPL, 16'h0000, 1'b0, FSP_EXC_VEC, 1,
          CAUSE_UNIMPL);
    t_ctl(CLS_MUL, 16'h0000, 1'b0, FSP_EXC_VEC, 1, CAUSE_UNIMPL);
    t_ctl(CLS_BRANCH, 16'h0010, 1'b1, 32'h0000_0018, 1,
          CAUSE_NONE);
    t_ctl(CLS_BRANCH, 16'hfff8, 1'b0, 32'h0000_0008, 1,
          CAUSE_NONE);
    t_ctl(CLS_BRANCH, 16'hfff8, 1'b1, 32'h0000_0000, 0,
          CAUSE_NONE);
    t_irq();
    give_verdict();
  end
endmodule : fsp_core_ctl_bench

// ### test/fsp_core_ctl_sva.sv
// Port assertions for the five-stage pipeline control
`timescale 1ns/1ps
module fsp_core_ctl_sva
(
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire fsp_pkg::fsp_ibus_in_t  ib_in,
  input wire fsp_pkg::fsp_ibus_out_t ib_out,
  input wire fsp_pkg::fsp_dbus_in_t  db_in,
  input wire fsp_pkg::fsp_dbus_out_t db_out,
  input wire logic                   ci_stall,
  input wire logic                   ci_start,
  input wire logic                   dispatch,
  input wire fsp_pkg::fsp_ret_t      retire,
  input wire logic                   flush
);
  import fsp_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Custom instruction enters M, stall line seen one cycle later
  sequence s_ci_held;
    ci_start ##1 ci_stall;
  endsequence
  sequence s_ci_free;
    ci_start ##1 !ci_stall;
  endsequence

  property p_ib_hold;
    ib_out.read && ib_in.waitrequest |=>
      ib_out.read && $stable(ib_out.address);
  endproperty
  a_ib_hold: assert property (p_ib_hold)
    else $error("fetch request not held");

  // Only one fetch may be outstanding
  property p_ib_one;
    ib_out.read && !ib_in.waitrequest |=> !ib_out.read;
  endproperty
  a_ib_one: assert property (p_ib_one)
    else $error("second fetch while one pending");

  property p_db_hold;
    (db_out.read || db_out.write) && db_in.waitrequest |=>
      db_out == $past(db_out);
  endproperty
  a_db_hold: assert property (p_db_hold)
    else $error("data strobe changed while refused");

  // A refused data access stops dispatch and retirement the next cycle
  property p_stall;
    (db_out.read || db_out.write) && db_in.waitrequest |=>
      !dispatch && !retire.valid;
  endproperty
  a_stall: assert property (p_stall)
    else $error("pipe moved during data stall");

  property p_ld_ret;
    db_in.readdatavalid |=> retire.valid;
  endproperty
  a_ld_ret: assert property (p_ld_ret)
    else $error("load did not retire after data");

  property p_st_ret;
    db_out.write && !db_in.waitrequest |-> ##2 retire.valid;
  endproperty
  a_st_ret: assert property (p_st_ret)
    else $error("store did not retire two cycles on");

  property p_ci_held;
    s_ci_held |=> !retire.valid;
  endproperty
  a_ci_held: assert property (p_ci_held)
    else $error("custom op left M while stalling");

  property p_ci_free;
    s_ci_free |=> retire.valid;
  endproperty
  a_ci_free: assert property (p_ci_free)
    else $error("custom op late after stall release");

  // Cancelled younger instructions never reach writeback
  property p_flush;
    flush |=> !retire.valid [*3];
  endproperty
  a_flush: assert property (p_flush)
    else $error("retire inside flush shadow");
endmodule : fsp_core_ctl_sva

bind fsp_core_ctl fsp_core_ctl_sva fsp_core_ctl_sva_i (
  .clk(clk), .rst_n(rst_n), .ib_in(ib_in), .ib_out(ib_out),
  .db_in(db_in), .db_out(db_out), .ci_stall(ci_stall),
  .ci_start(ci_start), .dispatch(dispatch), .retire(retire),
  .flush(flush)
);

// ### test/fsp_far_model.sv
// Bus slaves, decoder and custom logic beside the pipeline control
`timescale 1ns/1ps
module fsp_far_model
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire fsp_pkg::fsp_ibus_out_t ib_out,
  output wire fsp_pkg::fsp_ibus_in_t  ib_in,
  input  wire logic [31:0]            d_instr,
  output wire fsp_pkg::fsp_dec_t      dec,
  input  wire fsp_pkg::fsp_dbus_out_t db_out,
  output wire fsp_pkg::fsp_dbus_in_t  db_in,
  input  wire logic                   ci_start,
  output wire logic                   ci_stall,
  input  wire logic [7:0]             iwait,
  input  wire logic [7:0]             dwait,
  input  wire logic [7:0]             ciwait
);
  import fsp_pkg::*;
  logic [31:0] mem [0:63]; // Program image, loaded only in reset
  logic [7:0]  iw_cnt;     // Refused cycles of the current fetch
  logic [7:0]  dw_cnt;     // Refused cycles of the current data access
  logic [7:0]  ci_cnt;     // Stall cycles still owed by custom logic
  logic [31:0] word;       // Last word handed back
  logic        ib_ok;      // Fetch data valid
  logic        db_ok;      // Load data valid
  logic        dstb;       // Any data strobe
  assign dstb = db_out.read | db_out.write;
  // Decoder: class [3:0], offset [19:4], shift count [24:20]
  assign dec = '{fsp_cls_t'(d_instr[3:0]), d_instr[19:4], d_instr[24:20]};
  // completion by wait release and data valid
  // Idle read data is inverted so a stale word never looks fresh
  assign ib_in = '{ib_out.read && iw_cnt != iwait, ib_ok,
                   ib_ok ? word : ~word};
  assign db_in = '{dstb && dw_cnt != dwait, db_ok};
  // stall held for the commanded count
  assign ci_stall = ci_cnt != 8'h00;

  // Wait counters, data return and custom stall count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      iw_cnt <= 8'h00;
      dw_cnt <= 8'h00;
      ci_cnt <= 8'h00;
      ib_ok  <= 1'b0;
      db_ok  <= 1'b0;
      word   <= 32'h0000_0000;
    end
    else
    begin
      ib_ok  <= ib_out.read && !ib_in.waitrequest;
      db_ok  <= db_out.read && !db_in.waitrequest;
      iw_cnt <= ib_in.waitrequest ? iw_cnt + 8'h01 : 8'h00;
      dw_cnt <= db_in.waitrequest ? dw_cnt + 8'h01 : 8'h00;
      ci_cnt <= ci_start ? ciwait : ci_cnt - {7'h00, ci_stall};
      if (ib_out.read && !ib_in.waitrequest)
        word <= mem[ib_out.address[7:2]];
    end
  end
endmodule : fsp_far_model
